// >>> dv/dsr_chk.sv
// Concurrent checks on the decorated store bridge ports.
`timescale 1ns/10ps
module dsr_chk (
  // Clock and reset.
  input wire        aclk,
  input wire        aresetn,
  // Register write channel, for the decode enable.
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  // Upstream side.
  input wire [31:0] up_haddr,
  input wire [1:0]  up_htrans,
  input wire        up_hwrite,
  input wire [2:0]  up_hsize,
  input wire [31:0] up_hwdata,
  input wire [31:0] up_hrdata,
  input wire        up_hready,
  // Downstream side.
  input wire [31:0] dn_haddr,
  input wire [1:0]  dn_htrans,
  input wire        downstream_write,
  input wire [2:0]  dn_hsize,
  input wire [31:0] dn_hwdata,
  input wire [31:0] dn_hrdata,
  input wire        downstream_ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg en_s;
  // Enable shadow, taken when the control address is accepted; data
  // is offered together with the address, so it stands then too.
  always @(posedge aclk) begin
    if (!aresetn)
      en_s <= 1'b1;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00
             && s_axi_wstrb[0])
      en_s <= s_axi_wdata[0];
  end
  // Decode kept apart from the design so a shared slip cannot hide.
  wire take = up_hready && up_htrans[1];
  wire dec = take && up_hwrite && en_s && up_haddr[31:29] == 3'h2;
  wire xo = dec && up_haddr[28:26] == 3'h3;
  wire bf = dec && up_haddr[28];
  wire [4:0] wp1 = {1'b0, up_haddr[22:19]} + 5'h1;
  reg [31:0] m_q;
  // Word insert mask, held from the address phase to the write.
  always @(posedge aclk) begin
    if (bf)
      m_q <= ((32'h1 << wp1) - 32'h1) << up_haddr[27:23];
  end
  sequence xo_rd;
    xo && up_hsize == 3'h2 ##1 downstream_ready;
  endsequence
  sequence bf_rd;
    bf && up_hsize == 3'h2 ##1 downstream_ready;
  endsequence
  xor_strip_a: assert property (
    xo |-> dn_haddr == (up_haddr & 32'he00fffff) && !downstream_write)
    else $error("xor read address wrong");
  bfi_strip_a: assert property (
    bf |-> dn_haddr == (up_haddr & 32'he007ffff) && !downstream_write)
    else $error("insert read address wrong");
  rewrite_a: assert property (
    xo || bf |=> downstream_write && !up_hready
      && dn_haddr == $past(dn_haddr) && dn_hsize == $past(up_hsize))
    else $error("second phase not a stalled write");
  wait_pass_a: assert property (
    (xo || bf) ##1 !downstream_ready |=> !up_hready && downstream_write)
    else $error("slave wait not held");
  xor_data_a: assert property (
    xo_rd |=> dn_hwdata == ($past(dn_hrdata) ^ $past(up_hwdata))
      && up_hready == downstream_ready)
    else $error("xor write data wrong");
  bfi_data_a: assert property (
    bf_rd |=> dn_hwdata == (($past(dn_hrdata) & ~m_q)
      | ($past(up_hwdata) & m_q)))
    else $error("insert write data wrong");
  plain_pass_a: assert property (
    take && (up_haddr[28:26] == 3'h0 || !en_s) |-> dn_haddr == up_haddr
      && downstream_write == up_hwrite && dn_htrans == up_htrans)
    else $error("plain transfer altered");
  rdata_pass_a: assert property (
    take && !up_hwrite ##1 downstream_ready |-> up_hrdata == dn_hrdata
      && up_hready)
    else $error("read data not passed");
endmodule // dsr_chk

bind dsr_bridge dsr_chk u_dsr_chk (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .s_axi_awaddr     (s_axi_awaddr),
  .s_axi_awvalid    (s_axi_awvalid),
  .s_axi_awready    (s_axi_awready),
  .s_axi_wdata      (s_axi_wdata),
  .s_axi_wstrb      (s_axi_wstrb),
  .up_haddr         (up_haddr),
  .up_htrans        (up_htrans),
  .up_hwrite        (up_hwrite),
  .up_hsize         (up_hsize),
  .up_hwdata        (up_hwdata),
  .up_hrdata        (up_hrdata),
  .up_hready        (up_hready),
  .dn_haddr         (dn_haddr),
  .dn_htrans        (dn_htrans),
  .downstream_write (downstream_write),
  .dn_hsize         (dn_hsize),
  .dn_hwdata        (dn_hwdata),
  .dn_hrdata        (dn_hrdata),
  .downstream_ready (downstream_ready)
);

// >>> dv/dsr_slave_model.sv
// Behavioural peripheral slave: small word memory and wait states.
`timescale 1ns/10ps
module dsr_slave_model (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // Wait states added to every data phase.
  input  wire [3:0]  waits,
  // Slave side of the bridge.
  input  wire [31:0] dn_haddr,
  input  wire [1:0]  dn_htrans,
  input  wire        downstream_write,
  input  wire [2:0]  dn_hsize,
  input  wire [31:0] dn_hwdata,
  output wire [31:0] dn_hrdata,
  output wire        downstream_ready,
  output wire        dn_hresp
);
  reg [31:0] mem_q [0:15];
  reg        act_q;
  reg        wr_q;
  reg [3:0]  idx_q;
  reg [1:0]  lo_q;
  reg [2:0]  sz_q;
  reg [3:0]  cnt_q;
  integer    i;
  // Ready drops for the programmed count in each data phase.
  assign downstream_ready = !act_q || cnt_q == 4'h0;
  assign dn_hresp = 1'b0;
  // Off a read phase the bus shows the inverse, so stale data is caught.
  assign dn_hrdata = (act_q && !wr_q) ? mem_q[idx_q] : ~mem_q[idx_q];
  // Only the byte lanes that the size reaches are written.
  always @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!downstream_ready) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        if (act_q && wr_q && (sz_q == 3'h2 || (sz_q == 3'h1 &&
            lo_q[1] == i[1]) || (sz_q == 3'h0 && lo_q == i[1:0])))
          mem_q[idx_q][8*i +: 8] <= dn_hwdata[8*i +: 8];
      act_q <= dn_htrans[1];
      wr_q  <= downstream_write;
      idx_q <= dn_haddr[5:2];
      lo_q  <= dn_haddr[1:0];
      sz_q  <= dn_hsize;
      cnt_q <= waits;
    end
  end
endmodule // dsr_slave_model

// >>> dv/test_decorated_store_rmw.sv
// Self-checking bench for the decorated store bridge.
`timescale 1ns/10ps
`include "dsr_map.vh"
module test_decorated_store_rmw;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, up_haddr, up_hwdata, rd;
  logic [3:0]  s_axi_wstrb, waits;
  logic [1:0]  up_htrans;
  logic        up_hwrite;
  logic [2:0]  up_hsize;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, up_hready, up_hresp;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, dn_htrans;
  wire  [31:0] s_axi_rdata, up_hrdata, dn_haddr, dn_hwdata, dn_hrdata;
  wire         downstream_write, downstream_ready, dn_hresp;
  wire  [2:0]  dn_hsize;
  int          num_errors = 0, num_checks = 0, cycles = 0;
  // Decorated store table: address, size, operand, word afterwards.
  logic [31:0] op_a [7] = '{32'h4c0000a0, 32'h4ff000a0, 32'h4c0000a1,
    32'h531000a0, 32'h547800a0, 32'h518000a0, 32'h4c0000a2};
  logic [2:0]  op_s [7] = '{3'h2, 3'h2, 3'h0, 3'h0, 3'h2, 3'h2, 3'h1};
  logic [31:0] op_w [7] = '{32'h0f0f00ff, 32'h0f0f00ff, 32'h81818181,
    32'h80808080, 32'h00abcd00, 32'h00000000, 32'hffffffff};
  logic [31:0] op_e [7] = '{32'h1d3b5687, 32'h12345678, 32'h1234d778,
    32'h1234d7b8, 32'h12abcdb8, 32'h12abcdb0, 32'hed54cdb0};

  dsr_bridge u_dsr_bridge (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .up_haddr         (up_haddr),
    .up_htrans        (up_htrans),
    .up_hwrite        (up_hwrite),
    .up_hsize         (up_hsize),
    .up_hwdata        (up_hwdata),
    .up_hrdata        (up_hrdata),
    .up_hready        (up_hready),
    .up_hresp         (up_hresp),
    .dn_haddr         (dn_haddr),
    .dn_htrans        (dn_htrans),
    .downstream_write (downstream_write),
    .dn_hsize         (dn_hsize),
    .dn_hwdata        (dn_hwdata),
    .dn_hrdata        (dn_hrdata),
    .downstream_ready (downstream_ready),
    .dn_hresp         (dn_hresp)
  );
  dsr_slave_model u_dsr_slave_model (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .waits            (waits),
    .dn_haddr         (dn_haddr),
    .dn_htrans        (dn_htrans),
    .downstream_write (downstream_write),
    .dn_hsize         (dn_hsize),
    .dn_hwdata        (dn_hwdata),
    .dn_hrdata        (dn_hrdata),
    .downstream_ready (downstream_ready),
    .dn_hresp         (dn_hresp)
  );

  // Free-running clock, 100 MHz.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // A hang is cut short at 5000 cycles, far beyond the under two hundred needed.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer, address phase then data phase, no pipelining.
  task ahb(input [31:0] a, input [2:0] sz, input wr, input [31:0] wd);
    up_haddr <= a;
    up_hsize <= sz;
    up_hwrite <= wr;
    up_htrans <= `DSR_TR_NSEQ;
    do @(posedge aclk); while (!up_hready);
    up_htrans <= 2'h0;
    up_hwdata <= wd;
    do @(posedge aclk); while (!up_hready);
    rd = up_hrdata;
    chk(up_hresp, 32'h0);
  endtask

  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      dd = dd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end while (!(ad && dd));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // Register reset value, an unmapped place both ways, enable rewritten.
  task run_regs;
    axi_rd(`DSR_A_CTRL, 32'h1, `DSR_AXI_OKAY);
    axi_wr(8'h40, 32'h0, `DSR_AXI_SLVERR);
    axi_rd(8'h40, 32'h0, `DSR_AXI_SLVERR);
    axi_wr(`DSR_A_CTRL, 32'h1, `DSR_AXI_OKAY);
  endtask

  // Plain word write and read must pass straight through.
  task run_plain;
    ahb(32'h400000a0, 3'h2, 1'b1, 32'h12345678);
    ahb(32'h400000a0, 3'h2, 1'b0, 32'h0);
    chk(rd, 32'h12345678);
  endtask

  // Both store kinds in every size but a halfword insert, with and without slave waits, read back.
  task run_ops;
    for (int i = 0; i < 7; i++) begin
      waits <= i[0] ? 4'h2 : 4'h0;
      ahb(op_a[i], op_s[i], 1'b1, op_w[i]);
      ahb(32'h400000a0, 3'h2, 1'b0, 32'h0);
      chk(rd, op_e[i]);
    end
    waits <= 4'h0;
  endtask

  // Decode switched off: a decorated address is a plain write.
  task run_off;
    axi_wr(`DSR_A_CTRL, 32'h0, `DSR_AXI_OKAY);
    axi_rd(`DSR_A_CTRL, 32'h0, `DSR_AXI_OKAY);
    ahb(32'h4c0000a0, 3'h2, 1'b1, 32'h0f0f00ff);
    ahb(32'h400000a0, 3'h2, 1'b0, 32'h0);
    chk(rd, 32'h0f0f00ff);
    axi_wr(`DSR_A_CTRL, 32'h1, `DSR_AXI_OKAY);
  endtask

  // Seven stores done, the last an xor, nothing in flight.
  task run_count;
    axi_rd(`DSR_A_CNT, 32'h7, `DSR_AXI_OKAY);
    axi_rd(`DSR_A_STAT, 32'h0, `DSR_AXI_OKAY);
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Reset for sixteen cycles, then the scenarios in turn.
  initial begin
    aresetn = 1'b0;
    waits = 4'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    up_haddr = 32'h0;
    up_hwdata = 32'h0;
    up_htrans = 2'h0;
    up_hwrite = 1'b0;
    up_hsize = 3'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    run_regs;
    run_plain;
    run_ops;
    run_off;
    run_count;
    print_verdict;
  end
endmodule // test_decorated_store_rmw

// >>> rtl/dsr_bridge.v
// Decorated store bridge: AHB pass-through with atomic xor/insert.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "dsr_map.vh"

// Contract
// - Xor store reads, xors, writes back atomically.
// - Operand size byte, halfword or word from write.
// - Xor store when address bits 28:26 are 011.
// - Xor store address masked with e00fffff.
// - First phase forwards read, next reissues write.
// - Read phase computes, registers result, stalls master.
// - Second data phase drives registered result.
// - Field insert replaces w+1 bits at b.
// - Insert when bit 28 set; fields 27:23, 22:19.
// - Insert uses bit 19; address masked e007ffff.
// - Width code zero inserts a single bit.
// - Mask is ((1<<(w+1))-1)<<b, merge by mask.
// - Overflowing field bits beyond container are dropped.
// - Read phase registers mask-selected write/read bits.
// - Slave wait states pass straight to master.

module dsr_bridge (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite register slave.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Upstream AHB port facing the core.
  input  wire [31:0] up_haddr,
  input  wire [1:0]  up_htrans,
  input  wire        up_hwrite,
  input  wire [2:0]  up_hsize,
  input  wire [31:0] up_hwdata,
  output wire [31:0] up_hrdata,
  output reg         up_hready,
  output reg         up_hresp,
  // Downstream AHB port facing the peripherals.
  output reg  [31:0] dn_haddr,
  output reg  [1:0]  dn_htrans,
  output reg         downstream_write,
  output reg  [2:0]  dn_hsize,
  output reg  [31:0] dn_hwdata,
  input  wire [31:0] dn_hrdata,
  input  wire        downstream_ready,
  input  wire        dn_hresp
);

  // One-hot sequencer states.
  localparam [2:0] ST_PASS  = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_WRITE = 3'h4;

  // Sequencer and captured transfer.
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [31:0] cap_addr_q;
  reg  [2:0]  cap_size_q;
  reg         cap_bfi_q;
  reg  [4:0]  cap_pos_q;
  reg  [3:0]  cap_wm1_q;
  reg  [31:0] mod_q;

  // Software-visible state.
  reg         en_q;
  reg         last_bfi_q;
  reg  [31:0] cnt_q;

  // AXI write channel bookkeeping.
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  // Decoder and modify results.
  wire        dec_xor;
  wire        dec_bfi;
  wire [31:0] dec_addr;
  wire [4:0]  dec_pos;
  wire [3:0]  dec_wm1;
  wire [31:0] mod_val;
  wire        dec_hit;
  wire        upstream_write;
  wire        ap_open;
  wire        take_rmw;

  // True when the byte address hits one of the three registers.
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `DSR_A_CTRL) | (a == `DSR_A_STAT) |
                  (a == `DSR_A_CNT);
    end
  endfunction

  // Register read mux; unmapped words read as zero.
  function [31:0] reg_read;
    input [7:0] a;
    begin
      reg_read = `DSR_ZERO;
      if (a == `DSR_A_CTRL) begin
        reg_read[`DSR_CTRL_EN] = en_q;
      end else if (a == `DSR_A_STAT) begin
        reg_read[1:0] = {last_bfi_q, state_q != ST_PASS};
      end else if (a == `DSR_A_CNT) begin
        reg_read = cnt_q;
      end
    end
  endfunction

  // Address decode on the live upstream address phase.
  dsr_decode u_decode (
    .addr      (up_haddr),
    .enable    (en_q),
    .is_xor    (dec_xor),
    .is_bfi    (dec_bfi),
    .real_addr (dec_addr),
    .fld_pos   (dec_pos),
    .fld_wm1   (dec_wm1)
  );

  // Modify uses the held upstream write data; the master keeps it
  // stable because its data phase is stalled.
  dsr_modify u_modify (
    .rdata  (dn_hrdata),
    .wdata  (up_hwdata),
    .is_bfi (cap_bfi_q),
    .size   (cap_size_q),
    .lane   (cap_addr_q[1:0]),
    .pos    (cap_pos_q),
    .wm1    (cap_wm1_q),
    .result (mod_val)
  );

  // An address phase is sampled whenever the master sees ready.
  assign upstream_write = up_htrans[1] & up_hwrite;
  assign dec_hit        = dec_xor | dec_bfi;
  assign ap_open        = (state_q != ST_READ) & downstream_ready;
  assign take_rmw       = ap_open & upstream_write & dec_hit;

  // Read data always comes straight from the slave.
  assign up_hrdata = dn_hrdata;

  // Bus routing is combinational so plain traffic sees no added
  // latency; only the read phase of a decorated store is held.
  // The cost is a longer path from the slave to the master pins.
  always @* begin
    if (state_q == ST_READ) begin
      dn_haddr         = cap_addr_q;
      dn_htrans        = `DSR_TR_NSEQ;
      downstream_write = 1'b1;
      dn_hsize         = cap_size_q;
      up_hready        = 1'b0;
      up_hresp         = `DSR_HRESP_OK;
    end else begin
      dn_haddr         = dec_addr;
      dn_htrans        = up_htrans;
      downstream_write = up_hwrite & ~dec_hit;
      dn_hsize         = up_hsize;
      up_hready        = downstream_ready;
      up_hresp         = dn_hresp;
    end
  end

  // Write data: registered result in the second data phase.
  always @* begin
    if (state_q == ST_WRITE) begin
      dn_hwdata = mod_q;
    end else begin
      dn_hwdata = up_hwdata;
    end
  end

  // Sequencer: every step waits on slave ready, so slave wait
  // states stretch the sequence cycle for cycle.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_PASS: begin
        if (take_rmw) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (downstream_ready) begin
          state_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // A decorated store right behind this one reads now.
        if (take_rmw) begin
          state_d = ST_READ;
        end else if (downstream_ready) begin
          state_d = ST_PASS;
        end
      end
      default: begin
        state_d = ST_PASS;
      end
    endcase
  end

  // Sequencer state and captured address phase.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_PASS;
      cap_addr_q <= `DSR_ZERO;
      cap_size_q <= `DSR_SZ_BYTE;
      cap_bfi_q  <= 1'b0;
      cap_pos_q  <= 5'h00;
      cap_wm1_q  <= 4'h0;
    end else begin
      state_q <= state_d;
      if (take_rmw) begin
        cap_addr_q <= dec_addr;
        cap_size_q <= up_hsize;
        cap_bfi_q  <= dec_bfi;
        cap_pos_q  <= dec_pos;
        cap_wm1_q  <= dec_wm1;
      end
    end
  end

  // Result register is loaded when the read data phase ends.
  // Loading only on ready skips the stale bus during slave waits.
  always @(posedge aclk) begin
    if (!aresetn) begin
      mod_q <= `DSR_ZERO;
    end else if (state_q == ST_READ && downstream_ready) begin
      mod_q <= mod_val;
    end
  end

  // Completed operations counter and last operation kind.
  // The count wraps silently; software takes differences.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q      <= `DSR_ZERO;
      last_bfi_q <= 1'b0;
    end else if (state_q == ST_WRITE && downstream_ready) begin
      cnt_q      <= cnt_q + `DSR_ONE;
      last_bfi_q <= cap_bfi_q;
    end
  end

  // AXI write address and data, taken in either order. Ready
  // stays low once a beat is held so no second write can start.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= `DSR_ZERO;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_q      <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_got_q <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_q      <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_got_q <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write commit and response; read-only words ignore writes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DSR_AXI_OKAY;
      en_q         <= `DSR_CTRL_RST;
    end else begin
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_q) ? `DSR_AXI_OKAY :
                        `DSR_AXI_SLVERR;
        if (aw_addr_q == `DSR_A_CTRL && w_strb_q[0]) begin
          en_q <= w_data_q[`DSR_CTRL_EN];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answered the next cycle.
  // An unmapped word answers zero data with an error response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `DSR_ZERO;
      s_axi_rresp   <= `DSR_AXI_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= reg_read(s_axi_araddr);
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? `DSR_AXI_OKAY :
                         `DSR_AXI_SLVERR;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dsr_bridge

// >>> rtl/dsr_decode.v
// Decoration decoder and address undecorator for the bridge.
`timescale 1ns/10ps
`include "dsr_map.vh"

module dsr_decode (
  // Incoming address and global enable.
  input  wire [31:0] addr,
  input  wire        enable,
  // Decoded operation and fields.
  output wire        is_xor,
  output wire        is_bfi,
  output wire [31:0] real_addr,
  output wire [4:0]  fld_pos,
  output wire [3:0]  fld_wm1
);

  wire in_rgn;

  // Only the peripheral region carries decorations.
  assign in_rgn = enable &
                  (addr[`DSR_RGN_HI:`DSR_RGN_LO] == `DSR_RGN);

  // Operation codes; bits 25 to 20 are ignored for the xor store.
  assign is_bfi = in_rgn & addr[`DSR_BFI_BIT];
  assign is_xor = in_rgn &
                  (addr[`DSR_OP_HI:`DSR_OP_LO] == `DSR_OP_XOR);

  // Field insert also claims bit 19, so its mask is narrower.
  assign real_addr = is_bfi ? (addr & `DSR_BFI_KEEP) :
                     is_xor ? (addr & `DSR_XOR_KEEP) :
                     addr;

  // Field position and width minus one.
  assign fld_pos = addr[`DSR_POS_HI:`DSR_POS_LO];
  assign fld_wm1 = addr[`DSR_WM1_HI:`DSR_WM1_LO];

endmodule // dsr_decode

// >>> rtl/dsr_map.vh
// Named constants for the decorated store read-modify-write bridge.
`ifndef DSR_MAP_VH
`define DSR_MAP_VH

// Peripheral region select in the upper address bits.
`define DSR_RGN_HI 31
`define DSR_RGN_LO 29
`define DSR_RGN 3'h2

// Decoration fields in the access address.
`define DSR_OP_HI 28
`define DSR_OP_LO 26
`define DSR_OP_XOR 3'h3
`define DSR_BFI_BIT 28
`define DSR_POS_HI 27
`define DSR_POS_LO 23
`define DSR_WM1_HI 22
`define DSR_WM1_LO 19

// Masks that strip the decoration from the address.
`define DSR_XOR_KEEP 32'he00fffff
`define DSR_BFI_KEEP 32'he007ffff

// Transfer sizes and container masks.
`define DSR_SZ_BYTE 3'h0
`define DSR_SZ_HALF 3'h1
`define DSR_MSK_BYTE 32'h000000ff
`define DSR_MSK_HALF 32'h0000ffff
`define DSR_MSK_WORD 32'hffffffff
`define DSR_ONE 32'h00000001
`define DSR_ZERO 32'h00000000

// Bus encodings.
`define DSR_TR_NSEQ 2'h2
`define DSR_HRESP_OK 1'h0
`define DSR_AXI_OKAY 2'h0
`define DSR_AXI_SLVERR 2'h2

// Register byte addresses, fields and reset values.
`define DSR_A_CTRL 8'h00
`define DSR_A_STAT 8'h04
`define DSR_A_CNT 8'h08
`define DSR_CTRL_EN 0
`define DSR_CTRL_RST 1'h1

`endif

// >>> rtl/dsr_modify.v
// Modify stage: xor or field insert on the value just read.
`timescale 1ns/10ps
`include "dsr_map.vh"

module dsr_modify (
  // Operands.
  input  wire [31:0] rdata,
  input  wire [31:0] wdata,
  // Operation attributes.
  input  wire        is_bfi,
  input  wire [2:0]  size,
  input  wire [1:0]  lane,
  input  wire [4:0]  pos,
  input  wire [3:0]  wm1,
  // Value to write back.
  output reg  [31:0] result
);

  reg [4:0]  sh;
  reg [31:0] cmask;
  reg [31:0] fmask;
  reg [31:0] rd_c;
  reg [31:0] ins;

  // For an insert the container is right-justified from its byte lane, modified,
  // then replicated so every lane carries the result.
  always @* begin
    sh = 5'h00;
    cmask = `DSR_MSK_WORD;
    if (size == `DSR_SZ_BYTE) begin
      sh = {lane, 3'h0};
      cmask = `DSR_MSK_BYTE;
    end else if (size == `DSR_SZ_HALF) begin
      sh = {lane[1], 4'h0};
      cmask = `DSR_MSK_HALF;
    end
    rd_c = rdata >> sh;
    // Clipping to the container drops overflowing field bits.
    fmask = (((`DSR_ONE << ({1'b0, wm1} + 5'h01)) - `DSR_ONE)
             << pos) & cmask;
    ins = (rd_c & ~fmask) | (wdata & fmask);
    if (size == `DSR_SZ_BYTE)
      ins = {4{ins[7:0]}};
    else if (size == `DSR_SZ_HALF)
      ins = {2{ins[15:0]}};
    // Lane replication by the master keeps xor lane-correct.
    result = is_bfi ? ins : (rdata ^ wdata);
  end

endmodule // dsr_modify
